// [inc/pm_ctl_pkg.sv]
// Purpose: shared constants for the power-management control and timer block
// Assumes: system I/O accesses carry a size code and lane-aligned data
// Notes: block base addresses and the bit split between blocks are module parameters
package pm_ctl_pkg;
  // access size codes on the I/O port
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;
  // control register layout
  localparam int ROUTE_BIT = 0;
  localparam int BM_WAKE_BIT = 1;
  localparam int GLOCK_BIT = 2;
  localparam int SLP_TYPE_LSB = 10;
  localparam int SLP_TYPE_MSB = 12;
  localparam int SLP_TRIG_BIT = 13;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [2:0] SLP_TYPE_RESET = 3'h0;
  // default split: first block holds all bits, second only the sleep fields
  localparam logic [15:0] FIRST_IMPL_DEFAULT = 16'h3C07;
  localparam logic [15:0] SECOND_IMPL_DEFAULT = 16'h3C00;
  // default I/O locations, each 32-bit aligned
  localparam logic [15:0] FIRST_BASE_DEFAULT = 16'h0404;
  localparam logic [15:0] SECOND_BASE_DEFAULT = 16'h0408;
  localparam logic [15:0] TIMER_BASE_DEFAULT = 16'h0410;
  localparam logic [31:0] COUNTER_INIT_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  // timer rate against the core clock, in hertz
  localparam longint CLK_HZ = 100_000_000;
  localparam real TIMER_MHZ = 3.579545;
  localparam longint TIMER_HZ = longint'(TIMER_MHZ * 1_000_000.0);
  localparam int PHASE_W = 28;
  localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(TIMER_HZ);
  localparam logic [PHASE_W-1:0] PHASE_MOD = PHASE_W'(CLK_HZ);
  localparam logic [PHASE_W-1:0] PHASE_RESET = 28'h0000000;
endpackage

// [rtl/pm_control_and_timer.sv]
// Purpose: two power control register blocks and the free-running power timer
// Assumes: I/O requests are one-cycle strobes, synchronous to clk, lane-aligned data
// Notes: timer ticks come from a phase accumulator on clk, gated by osc and working state
// Summary of operation
// - bits keep positions across blocks; absent bits read zero and ignore writes
// - each control block at its own aligned I/O address, resets to zero
// - control registers take byte and word accesses only
// - bit 0 routes power events to SCI when one, SMI when zero
// - only hardware changes the routing bit; software writes leave it
// - bit 1 lets a bus master request wake C3 processors to C0
// - writing one to bit 2 raises firmware SMI via its enable and flag
// - bits 3-9 and 14-15 read as zero
// - bits 10-12 hold the sleep type used when the trigger is written
// - bit 13 write-only trigger starting the sleep sequence, reads zero
// - timer register is read-only, 32 bits, accessed as a dword
// - counter is 24 or 32 bits, reported by the width flag
// - toggle of the counter's top bit sets the carry flag
// - low 24 bits return a count running at 3.579545 MHz in working state
// - counter start value is undefined; reset loads a chosen value
// - counter holds while the oscillator is stopped and resumes from there
// - bits 24-31 give upper count bits when wide, zero otherwise
// - enabled carry flag raises an SCI when bit 0 is one, an SMI when it is zero
`timescale 1ns/1ps
`default_nettype none
module pm_control_and_timer
  import pm_ctl_pkg::*;
#(
  parameter logic [15:0] FIRST_BASE = FIRST_BASE_DEFAULT,
  parameter logic [15:0] SECOND_BASE = SECOND_BASE_DEFAULT,
  parameter logic [15:0] TIMER_BASE = TIMER_BASE_DEFAULT,
  parameter logic [15:0] FIRST_IMPL = FIRST_IMPL_DEFAULT,
  parameter logic [15:0] SECOND_IMPL = SECOND_IMPL_DEFAULT,
  parameter bit COUNTER_WIDE = 1'b1,
  parameter logic [31:0] COUNTER_INIT = COUNTER_INIT_DEFAULT
)
(
  input wire logic clk, // core clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [15:0] io_addr, // I/O byte address
  input wire logic io_rd, // read strobe
  input wire logic io_wr, // write strobe
  input wire logic [1:0] io_size, // byte, word or dword
  input wire logic [31:0] io_wdata, // lane-aligned write data
  output logic [31:0] io_rdata, // lane-aligned read data
  output logic io_ack, // access done pulse
  input wire logic route_set, // hardware sets routing bit
  input wire logic route_clear, // hardware clears routing bit
  input wire logic pm_event, // power event request pulse
  input wire logic bm_request, // bus master request
  input wire logic osc_running, // system oscillator running
  input wire logic sys_working, // system in working state
  input wire logic carry_irq_enable, // carry interrupt enable
  input wire logic carry_flag_clear, // clears carry flag
  input wire logic firmware_event_enable, // firmware SMI enable
  input wire logic firmware_flag_clear, // clears firmware flag
  output logic sci_out, // SCI request level
  output logic smi_out, // SMI request level
  output logic c3_wake, // wake C3 processors pulse
  output logic sleep_start, // sleep sequence start pulse
  output logic [2:0] sleep_type_first, // first block sleep code
  output logic [2:0] sleep_type_second, // second block sleep code
  output logic counter_carry_flag, // timer carry status
  output logic firmware_event_flag, // firmware event status
  output logic counter_width_flag // 1 = 32-bit counter
);

  // byte enables for a size at a byte offset within a dword
  function automatic logic [3:0] lanes(input logic [1:0] size, input logic [1:0] off);
    logic [3:0] be;
    be = 4'h0;
    if (size == SIZE_BYTE)
    begin
      be = 4'h1 << off;
    end
    else if (size == SIZE_WORD && !off[0])
    begin
      be = 4'h3 << off;
    end
    else if (size == SIZE_DWORD && off == 2'h0)
    begin
      be = 4'hF;
    end
    return be;
  endfunction

  // 16-bit control view for the lanes that hit the low or high half
  function automatic logic [15:0] half_mask(input logic [3:0] be, input logic [1:0] off);
    logic [15:0] m;
    m = 16'h0000;
    if (off[1])
    begin
      m = {{8{be[3]}}, {8{be[2]}}};
    end
    else
    begin
      m = {{8{be[1]}}, {8{be[0]}}};
    end
    return m;
  endfunction

  logic route_reg;
  logic bm_wake_reg;
  logic [2:0] type_first_reg;
  logic [2:0] type_second_reg;
  logic [31:0] count_reg;
  logic msb_prev_reg;
  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phase_sum;
  logic tick;
  logic [1:0] off;
  logic [3:0] be;
  logic hit_first;
  logic hit_second;
  logic hit_timer;
  logic ctrl_ok;
  logic [15:0] wmask_first;
  logic [15:0] wmask_second;
  logic [15:0] wdata16;
  logic [15:0] wr_bits;
  logic [15:0] view_first;
  logic [15:0] view_second;
  logic [31:0] timer_view;
  logic [31:0] rd_next;
  logic count_msb;
  logic event_pending;

  // address decode; each block is one aligned dword
  assign off = io_addr[1:0];
  assign be = lanes(io_size, off);
  assign hit_first = (io_addr[15:2] == FIRST_BASE[15:2]);
  assign hit_second = (io_addr[15:2] == SECOND_BASE[15:2]);
  assign hit_timer = (io_addr[15:2] == TIMER_BASE[15:2]);
  // control blocks are 16 bits wide at offset 0, byte or word only
  assign ctrl_ok = (io_size != SIZE_DWORD) && !off[1] && (be != 4'h0);
  assign wdata16 = io_wdata[15:0];
  assign wmask_first = (io_wr && hit_first && ctrl_ok) ? (half_mask(be, off) & FIRST_IMPL) : 16'h0000;
  assign wmask_second = (io_wr && hit_second && ctrl_ok) ? (half_mask(be, off) & SECOND_IMPL) : 16'h0000;
  assign wr_bits = (wmask_first | wmask_second) & wdata16;

  // read views; write-only and reserved bits are zero, absent bits masked
  assign view_first = {2'h0, 1'b0, type_first_reg, 7'h00, 1'b0, bm_wake_reg, route_reg} & FIRST_IMPL;
  assign view_second = {2'h0, 1'b0, type_second_reg, 7'h00, 1'b0, bm_wake_reg, route_reg} & SECOND_IMPL;

  // timer view, upper byte only when the counter is wide
  assign timer_view = COUNTER_WIDE ? count_reg : {8'h00, count_reg[23:0]};
  assign count_msb = COUNTER_WIDE ? count_reg[31] : count_reg[23];

  // read mux; unmapped or wrong-size accesses read zero
  always_comb
  begin
    rd_next = 32'h0000_0000;
    if (hit_first && ctrl_ok)
    begin
      rd_next = {view_first, view_first} & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
    else if (hit_second && ctrl_ok)
    begin
      rd_next = {view_second, view_second} & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
    else if (hit_timer && io_size == SIZE_DWORD && off == 2'h0)
    begin
      rd_next = timer_view;
    end
  end

  // bus answer: data and ack one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_rdata <= RDATA_RESET;
      io_ack <= 1'b0;
    end
    else
    begin
      io_rdata <= io_rd ? rd_next : RDATA_RESET;
      io_ack <= io_rd | io_wr;
    end
  end

  // routing bit: hardware only, software writes have no effect
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      route_reg <= CTRL_RESET[ROUTE_BIT];
    end
    else if (route_set)
    begin
      route_reg <= 1'b1;
    end
    else if (route_clear)
    begin
      route_reg <= 1'b0;
    end
  end

  // software-written control fields
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bm_wake_reg <= CTRL_RESET[BM_WAKE_BIT];
      type_first_reg <= SLP_TYPE_RESET;
      type_second_reg <= SLP_TYPE_RESET;
    end
    else
    begin
      if ((wmask_first[BM_WAKE_BIT] | wmask_second[BM_WAKE_BIT]))
      begin
        bm_wake_reg <= wdata16[BM_WAKE_BIT];
      end
      if (wmask_first[SLP_TYPE_LSB])
      begin
        type_first_reg <= wdata16[SLP_TYPE_MSB:SLP_TYPE_LSB];
      end
      if (wmask_second[SLP_TYPE_LSB])
      begin
        type_second_reg <= wdata16[SLP_TYPE_MSB:SLP_TYPE_LSB];
      end
    end
  end

  // sleep trigger: pulse out with the codes in force at that write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_start <= 1'b0;
      sleep_type_first <= SLP_TYPE_RESET;
      sleep_type_second <= SLP_TYPE_RESET;
    end
    else
    begin
      sleep_start <= wr_bits[SLP_TRIG_BIT];
      if (wr_bits[SLP_TRIG_BIT])
      begin
        // a type written in the same access takes effect with the trigger
        sleep_type_first <= wmask_first[SLP_TYPE_LSB] ? wdata16[SLP_TYPE_MSB:SLP_TYPE_LSB] : type_first_reg;
        sleep_type_second <= wmask_second[SLP_TYPE_LSB] ? wdata16[SLP_TYPE_MSB:SLP_TYPE_LSB] : type_second_reg;
      end
    end
  end

  // global lock release sets the firmware flag; set wins over clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      firmware_event_flag <= 1'b0;
    end
    else if (wr_bits[GLOCK_BIT])
    begin
      firmware_event_flag <= 1'b1;
    end
    else if (firmware_flag_clear)
    begin
      firmware_event_flag <= 1'b0;
    end
  end

  // bus master wake toward C3 processors
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c3_wake <= 1'b0;
    end
    else
    begin
      c3_wake <= bm_request & bm_wake_reg;
    end
  end

  // phase accumulator making 3.579545 MHz ticks from clk
  assign phase_sum = phase_reg + PHASE_STEP;
  assign tick = (phase_sum >= PHASE_MOD);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= PHASE_RESET;
    end
    else if (osc_running)
    begin
      phase_reg <= tick ? (phase_sum - PHASE_MOD) : phase_sum;
    end
  end

  // counter: runs in working state while the oscillator runs, wraps at all ones
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= COUNTER_INIT;
    end
    else if (tick && osc_running && sys_working)
    begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  // carry flag on any toggle of the top implemented bit; set wins over clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      msb_prev_reg <= COUNTER_WIDE ? COUNTER_INIT[31] : COUNTER_INIT[23]; // no false carry after reset
      counter_carry_flag <= 1'b0;
    end
    else
    begin
      msb_prev_reg <= count_msb;
      if (count_msb != msb_prev_reg)
      begin
        counter_carry_flag <= 1'b1;
      end
      else if (carry_flag_clear)
      begin
        counter_carry_flag <= 1'b0;
      end
    end
  end

  // event routing to SCI or SMI; firmware SMI from the lock release
  assign event_pending = pm_event | (counter_carry_flag & carry_irq_enable);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sci_out <= 1'b0;
      smi_out <= 1'b0;
      counter_width_flag <= 1'b0;
    end
    else
    begin
      sci_out <= event_pending & route_reg;
      smi_out <= (event_pending & ~route_reg) | (firmware_event_flag & firmware_event_enable);
      counter_width_flag <= COUNTER_WIDE;
    end
  end

endmodule
`default_nettype wire

// [verif/pm_control_and_timer_props.sv]
// Purpose: concurrent checks on the power control and timer ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module pm_control_and_timer_props
  import pm_ctl_pkg::*;
#(
  parameter logic [15:0] FIRST_BASE = FIRST_BASE_DEFAULT,
  parameter logic [15:0] TIMER_BASE = TIMER_BASE_DEFAULT,
  parameter bit COUNTER_WIDE = 1'b1
)
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [15:0] io_addr, // address
  input wire logic io_rd, // read
  input wire logic io_wr, // write
  input wire logic [1:0] io_size, // size
  input wire logic [31:0] io_wdata, // wdata
  input wire logic [31:0] io_rdata, // rdata
  input wire logic pm_event, // event
  input wire logic bm_request, // bus master
  input wire logic osc_running, // oscillator
  input wire logic sys_working, // working
  input wire logic carry_irq_enable, // carry en
  input wire logic firmware_event_enable, // fw en
  input wire logic sci_out, // sci
  input wire logic smi_out, // smi
  input wire logic c3_wake, // wake
  input wire logic sleep_start, // sleep
  input wire logic [2:0] sleep_type_first, // type
  input wire logic counter_carry_flag, // carry
  input wire logic firmware_event_flag, // fw flag
  input wire logic counter_width_flag // width
);
  logic ctl_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // write of the first block at offset zero
  assign ctl_wr = io_wr && io_addr == FIRST_BASE && io_size != SIZE_DWORD;

  property p_sleep_go;
    ctl_wr && io_size == SIZE_WORD && io_wdata[13] |=> sleep_start && sleep_type_first == $past(io_wdata[12:10]);
  endproperty
  a_sleep_go: assert property (p_sleep_go) else $error("sleep start or code wrong");
  property p_sleep_cause;
    sleep_start |-> $past(io_wr && io_wdata[13]);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep start without trigger");
  property p_wake;
    c3_wake |-> $past(bm_request);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without request");
  property p_sci;
    sci_out |-> $past(pm_event || (counter_carry_flag && carry_irq_enable));
  endproperty
  a_sci: assert property (p_sci) else $error("sci without cause");
  property p_both;
    sci_out && smi_out |-> $past(firmware_event_flag && firmware_event_enable);
  endproperty
  a_both: assert property (p_both) else $error("event routed both ways");
  property p_fw_set;
    ctl_wr && io_wdata[2] |=> firmware_event_flag ##1 (smi_out || !$past(firmware_event_enable));
  endproperty
  a_fw_set: assert property (p_fw_set) else $error("lock release not signalled");
  property p_carry;
    $rose(counter_carry_flag) |-> $past(osc_running && sys_working, 2);
  endproperty
  a_carry: assert property (p_carry) else $error("carry while stopped");
  property p_width;
    $past(rst_n) |-> counter_width_flag == COUNTER_WIDE;
  endproperty
  a_width: assert property (p_width) else $error("width flag wrong");
  property p_timer_top;
    $past(io_rd && io_addr == TIMER_BASE) && !COUNTER_WIDE |-> io_rdata[31:24] == 8'h00;
  endproperty
  a_timer_top: assert property (p_timer_top) else $error("upper timer bits not zero");
  property p_ctl_rsv;
    $past(io_rd && io_addr == FIRST_BASE) |-> io_rdata[15:13] == 3'h0 && io_rdata[9:2] == 8'h00;
  endproperty
  a_ctl_rsv: assert property (p_ctl_rsv) else $error("reserved control bits set");
  c_sleep: cover property (sleep_start);
  c_wake: cover property (c3_wake);
  c_carry: cover property ($rose(counter_carry_flag));
endmodule
bind pm_control_and_timer pm_control_and_timer_props #(.FIRST_BASE(FIRST_BASE), .TIMER_BASE(TIMER_BASE),
  .COUNTER_WIDE(COUNTER_WIDE)) i_props (.clk, .rst_n, .io_addr, .io_rd, .io_wr, .io_size, .io_wdata, .io_rdata,
  .pm_event, .bm_request, .osc_running, .sys_working, .carry_irq_enable, .firmware_event_enable, .sci_out,
  .smi_out, .c3_wake, .sleep_start, .sleep_type_first, .counter_carry_flag, .firmware_event_flag,
  .counter_width_flag);
`default_nettype wire

// [verif/pm_host_model.sv]
// Purpose: host software model issuing system I/O accesses
// Assumes: one-cycle strobes, answer one cycle after the strobe
// Notes: released address and data lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module pm_host_model
  import pm_ctl_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic [31:0] io_rdata, // read data
  input wire logic io_ack, // access done
  output logic [15:0] io_addr, // address
  output logic io_rd, // read strobe
  output logic io_wr, // write strobe
  output logic [1:0] io_size, // access size
  output logic [31:0] io_wdata // write data
);
  // idle bus at time zero
  initial
  begin
    {io_rd, io_wr, io_size, io_addr, io_wdata} = '0;
  end

  // one access: strobe for a cycle, then a bounded wait for the answer
  task automatic acc(input logic wr, input logic [15:0] a, input logic [1:0] sz, input logic [31:0] wd,
                     output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    @(negedge clk);
    {io_addr, io_size, io_wdata, io_wr, io_rd} = {a, sz, wd, wr, !wr};
    for (n = 0; n < 4 && !ok; n++)
    begin
      // answer stands from the edge after the strobe to the next edge
      @(negedge clk);
      if (n == 0)
      begin
        {io_addr, io_wdata, io_wr, io_rd} = {~a, ~wd, 2'b00};
      end
      ok = (io_ack === 1'b1);
      rd = io_rdata;
    end
  endtask
endmodule
`default_nettype wire

// [verif/tb_pm_control_and_timer.sv]
// Purpose: self-checking bench for the power control and timer block
// Assumes: narrow counter started near wrap so the carry comes early
// Notes: host accesses go through the host model
`timescale 1ns/1ps
`default_nettype none
module tb_pm_control_and_timer;
  import pm_ctl_pkg::*;
  localparam logic [15:0] FB = FIRST_BASE_DEFAULT;
  localparam logic [15:0] SB = SECOND_BASE_DEFAULT;
  localparam logic [15:0] TB = TIMER_BASE_DEFAULT;
  logic clk, rst_n, io_rd, io_wr, io_ack, route_set, route_clear, pm_event, bm_request, osc_running, sys_working;
  logic carry_irq_enable, carry_flag_clear, firmware_event_enable, firmware_flag_clear, sci_out, smi_out, c3_wake;
  logic sleep_start, counter_carry_flag, firmware_event_flag, counter_width_flag;
  logic [15:0] io_addr;
  logic [1:0] io_size;
  logic [31:0] io_wdata, io_rdata;
  logic [2:0] sleep_type_first, sleep_type_second;
  int error_cnt = 0;
  int checked = 0;
  int slp_cnt = 0;

  pm_host_model i_host (.clk(clk), .io_rdata(io_rdata), .io_ack(io_ack), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_size(io_size), .io_wdata(io_wdata));
  pm_control_and_timer #(.COUNTER_WIDE(1'b0), .COUNTER_INIT(32'h00FF_FFF0)) i_dut (.clk(clk), .rst_n(rst_n),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_size(io_size), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_ack(io_ack), .route_set(route_set), .route_clear(route_clear), .pm_event(pm_event),
    .bm_request(bm_request), .osc_running(osc_running), .sys_working(sys_working),
    .carry_irq_enable(carry_irq_enable), .carry_flag_clear(carry_flag_clear),
    .firmware_event_enable(firmware_event_enable), .firmware_flag_clear(firmware_flag_clear), .sci_out(sci_out),
    .smi_out(smi_out), .c3_wake(c3_wake), .sleep_start(sleep_start), .sleep_type_first(sleep_type_first),
    .sleep_type_second(sleep_type_second), .counter_carry_flag(counter_carry_flag),
    .firmware_event_flag(firmware_event_flag), .counter_width_flag(counter_width_flag));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // counts sleep start pulses
  always @(posedge clk) if (sleep_start === 1'b1) slp_cnt++;

  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [1:0] sz, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic ok;
    i_host.acc(wr, a, sz, wd, rd, ok);
    if (!ok)
    begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // reset values and width flag
  task automatic t_reset();
    logic [31:0] rd;
    xfer(1'b0, FB, SIZE_WORD, 32'h0, rd);
    chk(rd, 32'h0);
    xfer(1'b0, SB, SIZE_WORD, 32'h0, rd);
    chk(rd, 32'h0);
    chk(32'(counter_width_flag), 32'h0);
  endtask
  // field layout, triggers, split blocks, access sizes
  task automatic t_ctrl();
    logic [31:0] rd;
    xfer(1'b1, FB, SIZE_WORD, 32'h0000_FFFE, rd);
    cyc(2);
    chk({sleep_type_first, 28'h0, firmware_event_flag}, {3'h7, 28'h0, 1'b1});
    chk({slp_cnt[30:0], smi_out}, 32'h3);
    xfer(1'b0, FB, SIZE_WORD, 32'h0, rd);
    chk(rd, 32'h0000_1C02);
    xfer(1'b1, SB, SIZE_WORD, 32'h0000_FFFE, rd);
    cyc(2);
    chk({sleep_type_second, slp_cnt[28:0]}, {3'h7, 29'h2});
    xfer(1'b0, SB, SIZE_WORD, 32'h0, rd);
    chk(rd, 32'h0000_1C00);
    xfer(1'b1, FB + 16'h1, SIZE_BYTE, 32'h0000_0800, rd);
    xfer(1'b1, FB, SIZE_DWORD, 32'h0, rd);
    xfer(1'b0, FB, SIZE_WORD, 32'h0, rd);
    chk(rd, 32'h0000_0802);
    xfer(1'b0, FB, SIZE_DWORD, 32'h0, rd);
    chk(rd, 32'h0);
    firmware_event_enable = 1'b0;
    cyc(2);
    chk({firmware_event_flag, smi_out}, 32'h2);
    firmware_flag_clear = 1'b1;
    cyc(1);
    {firmware_flag_clear, firmware_event_enable} = 2'b01;
    cyc(2);
    chk({firmware_event_flag, smi_out}, 32'h0);
  endtask
  // event routing and bus master wake
  task automatic t_route();
    logic [31:0] rd;
    cyc(1);
    route_set = 1'b1;
    cyc(1);
    {route_set, pm_event, bm_request} = 3'b011;
    cyc(2);
    chk({sci_out, smi_out, c3_wake}, 32'h5);
    {pm_event, bm_request} = 2'b00;
    xfer(1'b0, FB, SIZE_WORD, 32'h0, rd);
    chk(rd, 32'h0000_0803);
    route_clear = 1'b1;
    cyc(1);
    {route_clear, pm_event} = 2'b01;
    cyc(2);
    chk({sci_out, smi_out}, 32'h1);
    pm_event = 1'b0;
    xfer(1'b1, FB, SIZE_BYTE, 32'h0000_0001, rd);
    xfer(1'b0, FB, SIZE_WORD, 32'h0, rd);
    chk(rd, 32'h0000_0800);
    cyc(1);
    bm_request = 1'b1;
    cyc(2);
    chk(32'(c3_wake), 32'h0);
    bm_request = 1'b0;
  endtask
  // count rate, carry, wrap, freeze, refused sizes
  task automatic t_timer();
    logic [31:0] a, b;
    int n;
    xfer(1'b0, TB, SIZE_DWORD, 32'h0, a);
    cyc(100);
    xfer(1'b0, TB, SIZE_DWORD, 32'h0, b);
    chk({b[31:24], 23'h0, (b[23:0] - a[23:0]) inside {24'h3, 24'h4}}, 32'h1);
    for (n = 0; n < 1000 && counter_carry_flag !== 1'b1; n++) cyc(1);
    if (counter_carry_flag !== 1'b1)
    begin
      error_cnt++;
      test_done();
    end
    route_set = 1'b1;
    cyc(2);
    chk({counter_carry_flag, sci_out}, 32'h2);
    {route_set, carry_irq_enable} = 2'b01;
    cyc(2);
    chk(32'(sci_out), 32'h1);
    carry_flag_clear = 1'b1;
    cyc(1);
    carry_flag_clear = 1'b0;
    cyc(2);
    chk({counter_carry_flag, sci_out}, 32'h0);
    xfer(1'b0, TB, SIZE_DWORD, 32'h0, a);
    chk(32'(a[23:0] < 24'h100), 32'h1);
    cyc(1);
    osc_running = 1'b0;
    xfer(1'b0, TB, SIZE_DWORD, 32'h0, a);
    cyc(200);
    xfer(1'b0, TB, SIZE_DWORD, 32'h0, b);
    chk(b, a);
    cyc(1);
    osc_running = 1'b1;
    cyc(100);
    xfer(1'b0, TB, SIZE_DWORD, 32'h0, b);
    chk(32'(b != a), 32'h1);
    sys_working = 1'b0;
    xfer(1'b0, TB, SIZE_DWORD, 32'h0, a);
    cyc(100);
    xfer(1'b0, TB, SIZE_DWORD, 32'h0, b);
    chk(b, a);
    sys_working = 1'b1;
    xfer(1'b0, TB, SIZE_WORD, 32'h0, b);
    chk(b, 32'h0);
  endtask

  // reset, then scenarios
  initial
  begin
    rst_n = 1'b0;
    {route_set, route_clear, pm_event, bm_request, carry_irq_enable, carry_flag_clear, firmware_flag_clear} = '0;
    {osc_running, sys_working, firmware_event_enable} = 3'b111;
    cyc(12);
    rst_n = 1'b1;
    t_reset();
    t_ctrl();
    t_route();
    t_timer();
    test_done();
  end
endmodule
`default_nettype wire
